// ---- rtl/word_write_device.sv ----
`timescale 1ns/10ps
// Operation
// - Sample data at falling clock, frame low
// - Host changes data on rising edges
// - Sixteen bits framed per transfer
// - Host frames every word separately
// - Split bytes keep frame low between
// - Most significant bit shifted first
// - Word splits control, address, data
// - Host idles clock high between writes
// - Frame signal is active low
module word_write_device #(
	parameter int sync_stages = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	word_link_if.device link,
	output logic word_valid,
	output logic [3:0] word_ctrl,
	output logic [3:0] word_addr,
	output logic [7:0] word_data
);
	import word_link_pkg::*;

	// --------------------------------------------------------------
	// How a frame is received
	// --------------------------------------------------------------
	// Link pins belong to the host's clock domain
	// Each pin crosses through its own synchroniser chain
	// Falling link edges found on the local clock
	// Sixteen edges inside one frame make one word
	// Short frames vanish when the frame pin rises
	// Extra edges past sixteen are ignored, not shifted
	// Limitation: each link clock phase needs two ref_clk cycles
	// Trade-off: commit lands a few cycles after the pin edge
	// Reset: chains and clk_last idle; count, shift, fields zero
	//
	// Walk of one bit, in ref_clk edges after the pin falls:
	//   edge 1  first stage holds the low level
	//   edge 2  last stage low, fall_edge high
	//   edge 3  bit in the shifter, count advanced
	// Sixteenth bit: word_valid and fields change at edge 3

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	logic clk_synced;
	logic data_synced;
	logic frame_synced;
	logic clk_last;
	logic fall_edge;
	logic frame_open;
	logic take_bit;
	logic word_done;
	word_type shift;
	logic [4:0] bit_count;
	logic [4:0] next_count;

	// Clock idles high; matching reset value avoids a false edge
	pin_sync #(
		.stages(sync_stages),
		.idle(link_clk_idle)
	) clk_sync_i (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin(link.serial_clk),
		.synced(clk_synced)
	);

	// Data takes as many stages as the clock, so samples stay paired
	pin_sync #(
		.stages(sync_stages),
		.idle(data_idle)
	) data_sync_i (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin(link.serial_data_in),
		.synced(data_synced)
	);

	// Frame idles high; no frame opens on reset release
	// Frame must fall a ref_clk cycle or more before the first edge
	pin_sync #(
		.stages(sync_stages),
		.idle(frame_idle)
	) frame_sync_i (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin(link.word_frame_n),
		.synced(frame_synced)
	);

	// --------------------------------------------------------------
	// Edge detection
	// --------------------------------------------------------------
	// Previous synced clock level, parked at idle in reset
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			clk_last <= link_clk_idle;
		end else begin
			clk_last <= clk_synced;
		end
	end

	// High for one cycle per falling link edge
	// Hazard: a glitch longer than a ref_clk cycle counts as an edge
	// The host's clean clock keeps this out; no filter is spent on it
	assign fall_edge = clk_last & ~clk_synced;

	// Frame pin is active low
	assign frame_open = ~frame_synced;

	// --------------------------------------------------------------
	// Shifter
	// --------------------------------------------------------------
	// Bit accepted only inside a frame and below the word length
	assign take_bit = frame_open && fall_edge && bit_count < 5'(word_bits);

	// This edge brings the sixteenth bit of the frame
	assign word_done = take_bit && bit_count == 5'(word_bits - 1);

	// Count step; never reached past sixteen
	assign next_count = bit_count + 5'h01;

	// Enters at the bottom, so the first bit ends up on top
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			shift <= word_reset;
		end else if (take_bit) begin
			shift <= {shift[14:0], data_synced};
		end
	end

	// Frame high clears the count, so a short frame is dropped
	// Count stops at sixteen; later edges of a long frame do nothing
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bit_count <= count_reset;
		end else if (!frame_open) begin
			bit_count <= count_reset;
		end else if (take_bit) begin
			bit_count <= next_count;
		end
	end

	// --------------------------------------------------------------
	// Commit
	// --------------------------------------------------------------
	// Word layout, most significant bit first:
	//   bits 15 to 12  control
	//   bits 11 to 8   destination address
	//   bits 7 to 0    data
	// Shift holds bits 15 to 1 at commit; bit 0 is still on data_synced

	// One-cycle pulse on the edge that completes the word
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			word_valid <= 1'h0;
		end else begin
			word_valid <= word_done;
		end
	end

	// Fields hold the last word until the next one lands
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			word_ctrl <= 4'h0;
			word_addr <= 4'h0;
			word_data <= 8'h00;
		end else if (word_done) begin
			word_ctrl <= shift[ctrl_msb - 1:ctrl_lsb - 1];
			word_addr <= shift[addr_msb - 1:addr_lsb - 1];
			word_data <= {shift[data_msb - 1:data_lsb], data_synced};
		end
	end
endmodule

// --------------------------------------------------------------
// Pin synchroniser
// --------------------------------------------------------------
// Only the first stage reads the pin; logic reads the last
module pin_sync #(
	parameter int stages = 2,
	parameter logic idle = 1'h0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic pin,
	output logic synced
);
	logic [stages - 1:0] chain;

	// A single stage would pass metastable levels to the logic
	if (stages < 2) begin : stages_check
		$error("pin_sync needs two stages or more");
	end

	// Chain starts at the idle level, so release brings no false edge
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			chain <= {stages{idle}};
		end else begin
			chain <= {chain[stages - 2:0], pin};
		end
	end

	// Last stage only; earlier stages may still be settling
	assign synced = chain[stages - 1];
endmodule

// ---- rtl/word_link_pkg.sv ----
package word_link_pkg;
	// --------------------------------------------------------------
	// Word layout
	// --------------------------------------------------------------
	localparam int word_bits = 16;
	localparam int byte_bits = 8;
	localparam int ctrl_msb = 15;
	localparam int ctrl_lsb = 12;
	localparam int addr_msb = 11;
	localparam int addr_lsb = 8;
	localparam int data_msb = 7;
	localparam int data_lsb = 0;
	localparam logic [15:0] word_reset = 16'h0000;
	localparam logic [4:0] count_reset = 5'h00;
	localparam logic link_clk_idle = 1'h1;
	localparam logic frame_idle = 1'h1;
	localparam logic data_idle = 1'h0;
	// --------------------------------------------------------------
	// Host timing: link clock half period in ref_clk cycles
	// --------------------------------------------------------------
	localparam int ref_clk_period_ns = 25;
	localparam int link_half_period_ns = 100;
	localparam int link_half_cycles = (link_half_period_ns + ref_clk_period_ns - 1)
		/ ref_clk_period_ns;
	localparam int gap_cycles = 4;
	typedef logic [15:0] word_type;
endpackage

// ---- rtl/word_link_if.sv ----
`timescale 1ns/10ps
interface word_link_if;
	logic serial_clk;
	logic serial_data_in;
	logic word_frame_n;
	modport host (output serial_clk, output serial_data_in, output word_frame_n);
	modport device (input serial_clk, input serial_data_in, input word_frame_n);
endinterface

// ---- rtl/word_write_host.sv ----
`timescale 1ns/10ps
module word_write_host (
	input wire logic ref_clk,
	input wire logic nrst,
	word_link_if.host link,
	input wire logic send_valid,
	input wire logic split_bytes,
	input wire word_link_pkg::word_type send_word,
	output logic send_ready
);
	import word_link_pkg::*;

	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_low = 4'h2,
		st_high = 4'h4,
		st_gap = 4'h8
	} state_type;

	state_type state;
	word_type shift;
	logic [4:0] bits_left;
	logic [7:0] timer;
	logic split;

	// --------------------------------------------------------------
	// Transmitter
	// --------------------------------------------------------------
	// Clock idles high; data changes at rising edge, MSB first
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= st_idle;
			shift <= word_reset;
			bits_left <= count_reset;
			timer <= 8'h00;
			split <= 1'h0;
			send_ready <= 1'h1;
			link.serial_clk <= 1'h1;
			link.serial_data_in <= 1'h0;
			link.word_frame_n <= 1'h1;
		end else begin
			case (state)
				st_idle: begin
					link.serial_clk <= 1'h1;
					link.word_frame_n <= 1'h1;
					send_ready <= 1'h1;
					if (send_valid && send_ready) begin
						send_ready <= 1'h0;
						shift <= {send_word[14:0], 1'h0};
						link.serial_data_in <= send_word[15];
						link.word_frame_n <= 1'h0;
						bits_left <= 5'(word_bits);
						split <= split_bytes;
						timer <= 8'(link_half_cycles);
						state <= st_high;
					end
				end
				st_high: begin
					timer <= timer - 8'h01;
					if (timer == 8'h01) begin
						link.serial_clk <= 1'h0;
						bits_left <= bits_left - 5'h01;
						timer <= 8'(link_half_cycles);
						state <= st_low;
					end
				end
				st_low: begin
					timer <= timer - 8'h01;
					if (timer == 8'h01) begin
						link.serial_clk <= 1'h1;
						timer <= 8'(link_half_cycles);
						if (bits_left == 5'h00) begin
							state <= st_gap;
						end else if (split && bits_left == 5'(byte_bits)) begin
							// Next bit goes out on this rising edge, then the clock rests
							link.serial_data_in <= shift[15];
							shift <= {shift[14:0], 1'h0};
							timer <= 8'(gap_cycles);
							state <= st_gap;
						end else begin
							link.serial_data_in <= shift[15];
							shift <= {shift[14:0], 1'h0};
							state <= st_high;
						end
					end
				end
				st_gap: begin
					// Frame held low through the byte gap, clock high
					timer <= timer - 8'h01;
					if (timer == 8'h01) begin
						if (bits_left == 5'h00) begin
							link.word_frame_n <= 1'h1;
							state <= st_idle;
						end else begin
							split <= 1'h0;
							timer <= 8'(link_half_cycles);
							state <= st_high;
						end
					end
				end
				default: state <= st_idle;
			endcase
		end
	end
endmodule

// ---- tb/word_link_assertions.sv ----
`timescale 1ns/10ps
module word_link_assertions (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic serial_clk,
	input wire logic serial_data_in,
	input wire logic word_frame_n
);
	// ----------------------------------------
	// Falling link edges within the open frame
	// ----------------------------------------
	logic [4:0] falls;
	always_ff @(posedge ref_clk) begin
		if (!nrst || word_frame_n)
			falls <= 5'h00;
		else if ($fell(serial_clk))
			falls <= falls + 5'h01;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	idle_clk_high_a: assert property (word_frame_n |-> serial_clk)
		else $error("link clock low while idle");
	data_hold_low_a: assert property (!serial_clk |-> $stable(serial_data_in))
		else $error("data moved while clock low");
	low_phase_a: assert property ($fell(serial_clk) |-> !serial_clk [*4] ##1 serial_clk)
		else $error("low phase not four cycles");
	frame_start_a: assert property ($fell(word_frame_n) |-> serial_clk [*4] ##1 !serial_clk)
		else $error("frame start clock wrong");
	word_count_a: assert property ($rose(word_frame_n) |-> falls == 5'h10)
		else $error("frame without sixteen bits");
	count_bound_a: assert property (falls <= 5'h10)
		else $error("more than sixteen bits");
	frame_gap_a: assert property ($rose(word_frame_n) |=> word_frame_n)
		else $error("no idle gap between words");
	end_hold_a: assert property ($rose(word_frame_n) |-> $past(serial_clk, 4) && serial_clk)
		else $error("frame closed too early");
	// Main traffic shapes
	cover property ($rose(word_frame_n));
	cover property (falls == 5'h08 && serial_clk && !word_frame_n [*5]);
	cover property ($fell(serial_clk) && falls == 5'h0f);
endmodule

// ---- tb/serial_word_write_port_test.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module serial_word_write_port_test;
	import word_link_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, send_valid = 1'b0, split_bytes = 1'b0, send_ready;
	logic word_valid, bad_valid;
	logic [3:0] word_ctrl, word_addr, bad_ctrl, bad_addr;
	logic [7:0] word_data, bad_data;
	word_type send_word = 16'h0000;
	word_type words [4] = '{16'hf0a5, 16'h5a3c, 16'h0001, 16'h8000};
	int n_mismatch = 0, comparisons = 0, n_bad = 0;
	word_link_if link();
	word_link_if bad_link();
	word_write_host word_write_host_i (.ref_clk(ref_clk), .nrst(nrst), .link(link),
		.send_valid(send_valid), .split_bytes(split_bytes), .send_word(send_word),
		.send_ready(send_ready));
	word_write_device word_write_device_i (.ref_clk(ref_clk), .nrst(nrst), .link(link),
		.word_valid(word_valid), .word_ctrl(word_ctrl), .word_addr(word_addr),
		.word_data(word_data));
	// Second device faces a bench driver that may cut frames short
	word_write_device word_write_device_i2 (.ref_clk(ref_clk), .nrst(nrst), .link(bad_link),
		.word_valid(bad_valid), .word_ctrl(bad_ctrl), .word_addr(bad_addr),
		.word_data(bad_data));
	word_link_assertions word_link_assertions_i (.ref_clk(ref_clk), .nrst(nrst),
		.serial_clk(link.serial_clk), .serial_data_in(link.serial_data_in),
		.word_frame_n(link.word_frame_n));
	// ----------------------------------------
	// Clock, bench link idle levels, pulse tally of the faulted device
	// ----------------------------------------
	always #12.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (bad_valid === 1'b1) n_bad++;
	initial begin
		bad_link.serial_clk = 1'b1;
		bad_link.serial_data_in = 1'b0;
		bad_link.word_frame_n = 1'b1;
	end
	task summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Sends n top bits of v, clock parked high outside the frame
	task raw(input word_type v, input int n);
		bad_link.word_frame_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			bad_link.serial_data_in = v[15 - i];
			repeat (4) @(negedge ref_clk);
			bad_link.serial_clk = 1'b0;
			repeat (4) @(negedge ref_clk);
			bad_link.serial_clk = 1'b1;
		end
		repeat (4) @(negedge ref_clk);
		bad_link.word_frame_n = 1'b1;
		repeat (8) @(negedge ref_clk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int t;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		foreach (words[k]) begin
			@(negedge ref_clk);
			{send_valid, split_bytes, send_word} = {1'b1, k[0], words[k]};
			t = 0;
			while (send_ready !== 1'b1 && ++t < 50) @(negedge ref_clk);
			`CHK("ready", 1'h1, send_ready)
			@(negedge ref_clk);
			send_valid = 1'b0;
			t = 0;
			while (word_valid !== 1'b1 && ++t < 400) @(negedge ref_clk);
			`CHK("valid", 1'h1, word_valid)
			`CHK("ctrl", words[k][15:12], word_ctrl)
			`CHK("addr", words[k][11:8], word_addr)
			`CHK("data", words[k][7:0], word_data)
		end
		raw(16'hc3ff, 8);
		`CHK("short frame pulses", 0, n_bad)
		raw(16'h9e42, 16);
		`CHK("pulses", 1, n_bad)
		`CHK("full word", 16'h9e42, {bad_ctrl, bad_addr, bad_data})
		summarize();
	end
	initial begin
		repeat (6000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
endmodule
